/* File: pxc_regs_map.svh */
// register offsets, field positions, reset values and timing constants
`ifndef PXC_REGS_MAP_SVH
`define PXC_REGS_MAP_SVH

// ---------------------------------------------------------------
// management frame layout
// ---------------------------------------------------------------
`define PXC_PREAMBLE_ONES 6'h20
`define PXC_HDR_BITS 4'hd
`define PXC_DATA_LAST 4'hf
`define PXC_OP_READ 2'h2
`define PXC_OP_WRITE 2'h1

// ---------------------------------------------------------------
// direct register addresses
// ---------------------------------------------------------------
`define PXC_ADDR_ERR_TALLY 5'h15
`define PXC_ADDR_INDEX 5'h1e
`define PXC_ADDR_WINDOW 5'h1f

// ---------------------------------------------------------------
// extended register indices
// ---------------------------------------------------------------
`define PXC_EXT_TEN_PWR 16'h200a
`define PXC_EXT_COMBO 16'h4000
`define PXC_EXT_PAD 16'h4001
`define PXC_EXT_COMBO2 16'h4003
`define PXC_EXT_ADDR_HIGH 16'h4004
`define PXC_EXT_ADDR_MID 16'h4005
`define PXC_EXT_ADDR_LOW 16'h4006

// ---------------------------------------------------------------
// reset values and the error tally saturation value
// ---------------------------------------------------------------
`define PXC_RST_ZERO 16'h0000
`define PXC_RST_TEN_PWR 16'hca02
`define PXC_RST_COMBO 16'h0000
`define PXC_RST_PAD 16'h80ef
`define PXC_RST_COMBO2 16'h0260
`define PXC_TALLY_MAX 16'hffff

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PXC_BIT_IDLE_DAC 10
`define PXC_BIT_REMOTE_LOOP 11
`define PXC_BIT_JUMBO 5
`define PXC_BIT_VALID_SRC 4
`define PXC_BIT_WAKE_ON 2
`define PXC_BIT_REDUCED 1
`define PXC_BIT_CLK_SEL 0
`define PXC_BIT_IRQ_SRC 15
`define PXC_BIT_JITTER 14
`define PXC_BIT_SHAPE_PULSE 7
`define PXC_BIT_SHAPE_HI 9
`define PXC_BIT_SHAPE_LO 8
`define PXC_BIT_ISO_TX 6
`define PXC_BIT_ISO_RX 5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PXC_CLK_PERIOD_NS 25
`define PXC_PULSE_10US_NS 10000
`define PXC_PULSE_100US_NS 100000
`define PXC_PULSE_1MS_NS 1000000
`define PXC_PULSE_10MS_NS 10000000

`endif

/* File: pxc_pkg.sv */
// types shared by the extended configuration register block
package pxc_pkg;
  // management frame receiver states, one-hot
  typedef enum logic [3:0] {
    PXC_IDLE = 4'h1,
    PXC_HDR = 4'h2,
    PXC_TURN = 4'h4,
    PXC_DATA = 4'h8
  } pxc_state_type;

  // serial interface mode as seen by the mac pins
  typedef enum logic [1:0] {
    PXC_MODE_MII = 2'h0,
    PXC_MODE_REDUCED_VARIANT_E = 2'h1,
    PXC_MODE_REDUCED_VARIANT_TWO = 2'h2,
    PXC_MODE_REDUCED_VARIANT_ONE = 2'h3
  } pxc_mac_mode_type;
endpackage : pxc_pkg

/* File: pxc_regs.sv */
// management register logic with indirect extended space
// Operation
// - error tally counts symbol errors and saturates at all ones
// - address 0x1e holds extended index, resets to zero
// - address 0x1f carries data of extended register selected by index
// - idle dac shutoff bit powers dac down in 10 mb idle
// - combo bit 11 enables remote loopback, resets zero
// - combo bit 5 allows 18 kb frames, else 4.5 kb
// - combo bit 4 picks rx valid or carrier valid for crs_dv pin
// - combo bit 2 enables wake detection, resets zero
// - combo bit 0 resets from strap; 1 clocks input, 0 output
// - combo bits 1:0 pick mii or one of three reduced modes
// - with strap set led0 carries general or wake interrupt per bit 15
// - shape field bit 7 makes wake interrupt pulse or level
// - shape bits 9:8 set pulse width 10us 100us 1ms 10ms
// - while isolated bit 6 forces tx clock pin to input
// - while isolated bit 5 forces rx clock pin to input
// - combo2 bit 14 routes dac clock onto rx clock output
// - station address 47:32 from extended register 0x4004
// - station address 31:16 from extended register 0x4005
// - station address 15:0 from extended register 0x4006
`timescale 1ns/1ps
`include "pxc_regs_map.svh"
module pxc_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int PULSE_1MS_CYCLES = `PXC_PULSE_1MS_NS / `PXC_CLK_PERIOD_NS,
  parameter int PULSE_10MS_CYCLES = `PXC_PULSE_10MS_NS / `PXC_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // serial management pins
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_N,
  // power-on straps
  input wire logic CLK_SEL_STRAP,
  input wire logic RECEIVE_DATA_ONE_STRAP_STRAP,
  // events and status from the transceiver core
  input wire logic RX_ERR_EVENT,
  input wire logic TEN_MEG_MODE,
  input wire logic TX_ACTIVE,
  input wire logic ISOLATE,
  input wire logic RX_DV_IN,
  input wire logic CRS_DV_IN,
  input wire logic GENERAL_IRQ,
  input wire logic WAKE_EVENT,
  input wire logic WAKE_IRQ_CLEAR,
  input wire logic LED0_STATUS,
  // controls to the transceiver core
  output logic DAC_POWER_ON,
  output logic REMOTE_LOOPBACK,
  output logic JUMBO_ENABLE,
  output logic CRS_DV_PIN,
  output logic WAKE_DETECT_ON,
  output pxc_pkg::pxc_mac_mode_type MAC_MODE,
  output logic TXC_IS_INPUT,
  output logic RXC_IS_INPUT,
  output logic RXC_FROM_DAC,
  output logic WAKE_IRQ,
  output logic LED0_PIN,
  output logic [47:0] WAKE_STATION_ADDR
);
  import pxc_pkg::*;
  localparam int PULSE_10US_CYCLES = `PXC_PULSE_10US_NS / `PXC_CLK_PERIOD_NS;
  localparam int PULSE_100US_CYCLES = `PXC_PULSE_100US_NS / `PXC_CLK_PERIOD_NS;
  // -------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------
  logic [15:0] receive_error_tally;
  logic [15:0] indirect_index;
  logic [15:0] ten_meg_power_control;
  logic [15:0] interface_combo_control;
  logic [15:0] pad_control;
  logic [15:0] interface_combo_control_two;
  logic [15:0] wake_station_addr_high;
  logic [15:0] wake_station_addr_mid;
  logic [15:0] wake_station_addr_low;
  // frame receiver state
  pxc_state_type state;
  logic mdc_prev;
  logic mdc_rise;
  logic [5:0] ones;
  logic [3:0] cnt;
  logic [15:0] shreg;
  logic [4:0] reg_addr;
  logic is_read;
  logic [15:0] rd_data;
  logic wr_strobe;
  logic rd_strobe;
  logic [15:0] wr_data;
  logic strap_pending;
  logic receive_data_one_strap_latched;
  logic [19:0] pulse_cnt;
  logic wake_level;
  logic wake_irq_now;
  // extended register read mux
  function automatic logic [15:0] ext_read(input logic [15:0] idx,
      input logic [15:0] pwr, input logic [15:0] cmb,
      input logic [15:0] pad, input logic [15:0] cmb2,
      input logic [15:0] ah, input logic [15:0] am, input logic [15:0] al);
    logic [15:0] v;
    v = `PXC_RST_ZERO;
    case (idx)
      `PXC_EXT_TEN_PWR: v = pwr;
      `PXC_EXT_COMBO: v = cmb;
      `PXC_EXT_PAD: v = pad;
      `PXC_EXT_COMBO2: v = cmb2;
      `PXC_EXT_ADDR_HIGH: v = ah;
      `PXC_EXT_ADDR_MID: v = am;
      `PXC_EXT_ADDR_LOW: v = al;
      default: v = `PXC_RST_ZERO;
    endcase
    return v;
  endfunction : ext_read
  // pulse width lookup from the shape field
  function automatic logic [19:0] pulse_width(input logic [1:0] sel);
    logic [19:0] w;
    w = 20'(PULSE_10US_CYCLES);
    case (sel)
      2'h0: w = 20'(PULSE_10US_CYCLES);
      2'h1: w = 20'(PULSE_100US_CYCLES);
      2'h2: w = 20'(PULSE_1MS_CYCLES);
      2'h3: w = 20'(PULSE_10MS_CYCLES);
      default: w = 20'(PULSE_10US_CYCLES);
    endcase
    return w;
  endfunction : pulse_width
  // -------------------------------------------------------------
  // management frame receiver
  // -------------------------------------------------------------
  // mdc edge detect on the synchronous pin sample
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= MDC;
    end
  end
  assign mdc_rise = MDC & ~mdc_prev;
  // frame sequencer: preamble, header, turnaround, data
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= PXC_IDLE;
      ones <= 6'h00;
      cnt <= 4'h0;
      shreg <= 16'h0000;
      reg_addr <= 5'h00;
      is_read <= 1'b0;
      rd_data <= 16'h0000;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      wr_data <= 16'h0000;
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b1;
    end else begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      if (mdc_rise) begin
        unique case (state)
          PXC_IDLE: begin
            if (MDIO_IN) begin
              if (ones != `PXC_PREAMBLE_ONES) ones <= ones + 6'h01;
            end else begin
              if (ones == `PXC_PREAMBLE_ONES) begin
                state <= PXC_HDR;
                cnt <= 4'h0;
              end
              ones <= 6'h00;
            end
          end
          PXC_HDR: begin
            shreg <= {shreg[14:0], MDIO_IN};
            cnt <= cnt + 4'h1;
            if (cnt == `PXC_HDR_BITS - 4'h1) begin
              // shreg[11] start bit 1, [10:9] op, [8:4] phy, [3:0]+in reg
              reg_addr <= {shreg[3:0], MDIO_IN};
              is_read <= (shreg[10:9] == `PXC_OP_READ);
              cnt <= 4'h0;
              // a bad start, phy address or op drops back to the hunt
              state <= (shreg[11] && shreg[8:4] == PHY_ADDR &&
                  (shreg[10:9] == `PXC_OP_READ ||
                   shreg[10:9] == `PXC_OP_WRITE)) ? PXC_TURN : PXC_IDLE;
            end
          end
          PXC_TURN: begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0) begin
              if (is_read) begin
                rd_strobe <= 1'b1; // latch and clear-on-read
                MDIO_OE_N <= 1'b0;
                MDIO_OUT <= 1'b0;
              end
            end else begin
              state <= PXC_DATA;
              cnt <= 4'h0;
              if (is_read) MDIO_OUT <= rd_data[15];
            end
          end
          PXC_DATA: begin
            cnt <= cnt + 4'h1;
            shreg <= {shreg[14:0], MDIO_IN};
            if (is_read && cnt != `PXC_DATA_LAST) begin
              MDIO_OUT <= rd_data[4'(`PXC_DATA_LAST - 4'h1 - cnt)];
            end
            if (cnt == `PXC_DATA_LAST) begin
              state <= PXC_IDLE;
              MDIO_OE_N <= 1'b1;
              MDIO_OUT <= 1'b1;
              if (!is_read) begin
                wr_strobe <= 1'b1;
                wr_data <= {shreg[14:0], MDIO_IN};
              end
            end
          end
        endcase
      end
      // read data captured the cycle after the strobe's request
      if (rd_strobe) begin
        unique case (reg_addr)
          `PXC_ADDR_ERR_TALLY: rd_data <= receive_error_tally;
          `PXC_ADDR_INDEX: rd_data <= indirect_index;
          `PXC_ADDR_WINDOW: rd_data <= ext_read(indirect_index,
              ten_meg_power_control, interface_combo_control, pad_control,
              interface_combo_control_two, wake_station_addr_high,
              wake_station_addr_mid, wake_station_addr_low);
          default: rd_data <= 16'h0000;
        endcase
      end
    end
  end
  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  // saturating tally; an error on the clearing read is kept
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      receive_error_tally <= `PXC_RST_ZERO;
    end else if (rd_strobe && reg_addr == `PXC_ADDR_ERR_TALLY) begin
      receive_error_tally <= {15'h0000, RX_ERR_EVENT};
    end else if (RX_ERR_EVENT && receive_error_tally != `PXC_TALLY_MAX) begin
      receive_error_tally <= receive_error_tally + 16'h0001;
    end
  end
  // indirect index register
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      indirect_index <= `PXC_RST_ZERO;
    end else if (wr_strobe && reg_addr == `PXC_ADDR_INDEX) begin
      indirect_index <= wr_data;
    end
  end
  // extended registers written through the window
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ten_meg_power_control <= `PXC_RST_TEN_PWR;
      interface_combo_control <= `PXC_RST_COMBO;
      pad_control <= `PXC_RST_PAD;
      interface_combo_control_two <= `PXC_RST_COMBO2;
      wake_station_addr_high <= `PXC_RST_ZERO;
      wake_station_addr_mid <= `PXC_RST_ZERO;
      wake_station_addr_low <= `PXC_RST_ZERO;
      strap_pending <= 1'b1;
      receive_data_one_strap_latched <= 1'b0;
    end else begin
      if (strap_pending) begin
        // straps caught on the first cycle after reset release
        interface_combo_control[`PXC_BIT_CLK_SEL] <= CLK_SEL_STRAP;
        receive_data_one_strap_latched <= RECEIVE_DATA_ONE_STRAP_STRAP;
        strap_pending <= 1'b0;
      end else if (wr_strobe && reg_addr == `PXC_ADDR_WINDOW) begin
        unique case (indirect_index)
          `PXC_EXT_TEN_PWR: ten_meg_power_control <= wr_data;
          `PXC_EXT_COMBO: interface_combo_control <= wr_data;
          `PXC_EXT_PAD: pad_control <= wr_data;
          `PXC_EXT_COMBO2: interface_combo_control_two <= wr_data;
          `PXC_EXT_ADDR_HIGH: wake_station_addr_high <= wr_data;
          `PXC_EXT_ADDR_MID: wake_station_addr_mid <= wr_data;
          `PXC_EXT_ADDR_LOW: wake_station_addr_low <= wr_data;
          default: ;
        endcase
      end
    end
  end
  // -------------------------------------------------------------
  // control outputs
  // -------------------------------------------------------------
  // static controls decoded from the extended registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DAC_POWER_ON <= 1'b1;
      REMOTE_LOOPBACK <= 1'b0;
      JUMBO_ENABLE <= 1'b0;
      CRS_DV_PIN <= 1'b0;
      WAKE_DETECT_ON <= 1'b0;
      MAC_MODE <= PXC_MODE_MII;
      TXC_IS_INPUT <= 1'b0;
      RXC_IS_INPUT <= 1'b0;
      RXC_FROM_DAC <= 1'b0;
      WAKE_STATION_ADDR <= 48'h000000000000;
    end else begin
      DAC_POWER_ON <= !(ten_meg_power_control[`PXC_BIT_IDLE_DAC] &&
                        TEN_MEG_MODE && !TX_ACTIVE);
      REMOTE_LOOPBACK <=
          interface_combo_control[`PXC_BIT_REMOTE_LOOP];
      JUMBO_ENABLE <= interface_combo_control[`PXC_BIT_JUMBO];
      CRS_DV_PIN <= interface_combo_control[`PXC_BIT_VALID_SRC] ?
                    RX_DV_IN : CRS_DV_IN;
      WAKE_DETECT_ON <= interface_combo_control[`PXC_BIT_WAKE_ON];
      MAC_MODE <= pxc_mac_mode_type'(
          {interface_combo_control[`PXC_BIT_REDUCED],
           interface_combo_control[`PXC_BIT_CLK_SEL]});
      // isolation can force a clock pin to input, else keep its direction
      TXC_IS_INPUT <= interface_combo_control[`PXC_BIT_CLK_SEL] ||
          (ISOLATE &&
           interface_combo_control_two[`PXC_BIT_ISO_TX]);
      RXC_IS_INPUT <= interface_combo_control[`PXC_BIT_CLK_SEL] ||
          (ISOLATE &&
           interface_combo_control_two[`PXC_BIT_ISO_RX]);
      RXC_FROM_DAC <= interface_combo_control_two[`PXC_BIT_JITTER];
      WAKE_STATION_ADDR <= {wake_station_addr_high,
                            wake_station_addr_mid,
                            wake_station_addr_low};
    end
  end
  // -------------------------------------------------------------
  // wake interrupt shaping and led0 routing
  // -------------------------------------------------------------
  // pulse counter and sticky level; a new event wins over the clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pulse_cnt <= 20'h00000;
      wake_level <= 1'b0;
    end else begin
      if (WAKE_EVENT) begin
        pulse_cnt <= pulse_width(interface_combo_control_two[
            `PXC_BIT_SHAPE_HI:`PXC_BIT_SHAPE_LO]);
      end else if (pulse_cnt != 20'h00000) begin
        pulse_cnt <= pulse_cnt - 20'h00001;
      end
      if (WAKE_EVENT) wake_level <= 1'b1;
      else if (WAKE_IRQ_CLEAR) wake_level <= 1'b0;
    end
  end
  assign wake_irq_now = interface_combo_control_two[`PXC_BIT_SHAPE_PULSE] ?
      (pulse_cnt != 20'h00000) : wake_level;
  // wake interrupt and led0 pin drive
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WAKE_IRQ <= 1'b0;
      LED0_PIN <= 1'b0;
    end else begin
      WAKE_IRQ <= wake_irq_now;
      if (receive_data_one_strap_latched) begin
        LED0_PIN <= pad_control[`PXC_BIT_IRQ_SRC] ?
                    GENERAL_IRQ : wake_irq_now;
      end else begin
        LED0_PIN <= LED0_STATUS;
      end
    end
  end
endmodule : pxc_regs

/* File: pxc_regs_checker.sv */
// assertion checker for the extended configuration register block
`timescale 1ns/1ps
module pxc_regs_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // pins and core status
  input wire logic MDIO_OE_N,
  input wire logic RECEIVE_DATA_ONE_STRAP_STRAP,
  input wire logic TEN_MEG_MODE,
  input wire logic TX_ACTIVE,
  input wire logic ISOLATE,
  input wire logic RX_DV_IN,
  input wire logic CRS_DV_IN,
  input wire logic WAKE_EVENT,
  input wire logic LED0_STATUS,
  // controls to the core
  input wire logic DAC_POWER_ON,
  input wire logic REMOTE_LOOPBACK,
  input wire logic JUMBO_ENABLE,
  input wire logic CRS_DV_PIN,
  input wire logic WAKE_DETECT_ON,
  input wire pxc_pkg::pxc_mac_mode_type MAC_MODE,
  input wire logic TXC_IS_INPUT,
  input wire logic RXC_IS_INPUT,
  input wire logic RXC_FROM_DAC,
  input wire logic WAKE_IRQ,
  input wire logic LED0_PIN,
  input wire logic [47:0] WAKE_STATION_ADDR
);
  import pxc_pkg::*;
  // ---------------------------------------------------------
  // properties
  // ---------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_dac_on_busy: assert property (
    (!TEN_MEG_MODE || TX_ACTIVE) |=> DAC_POWER_ON)
    else $error("dac off while not idle");
  a_valid_pin_follow: assert property (
    (RX_DV_IN == CRS_DV_IN) |=> CRS_DV_PIN == $past(RX_DV_IN))
    else $error("valid pin lost its source");
  a_clock_input_mode: assert property (
    MAC_MODE[0] |-> TXC_IS_INPUT && RXC_IS_INPUT)
    else $error("clock not input in this mode");
  a_iso_off_dir: assert property (
    !ISOLATE |=> TXC_IS_INPUT == MAC_MODE[0] && RXC_IS_INPUT == MAC_MODE[0])
    else $error("clock direction wrong when not isolated");
  a_wake_rise_cause: assert property (
    $rose(WAKE_IRQ) |-> $past(WAKE_EVENT) || $past(WAKE_EVENT, 2))
    else $error("wake interrupt without event");
  a_led_status_path: assert property (
    !RECEIVE_DATA_ONE_STRAP_STRAP |=> LED0_PIN == $past(LED0_STATUS))
    else $error("led pin not on status");
  a_cfg_write_only: assert property (
    $changed({REMOTE_LOOPBACK, JUMBO_ENABLE, WAKE_DETECT_ON, RXC_FROM_DAC})
    |-> MDIO_OE_N)
    else $error("control changed during a read");
  a_mode_write_only: assert property (
    $changed(MAC_MODE) |-> MDIO_OE_N)
    else $error("mode changed during a read");
  a_addr_high_word: assert property (
    $changed(WAKE_STATION_ADDR[47:32]) |-> $stable(WAKE_STATION_ADDR[31:0]))
    else $error("high word write touched others");
  a_addr_mid_word: assert property (
    $changed(WAKE_STATION_ADDR[31:16])
    |-> $stable({WAKE_STATION_ADDR[47:32], WAKE_STATION_ADDR[15:0]}))
    else $error("mid word write touched others");
  // main scenarios reached
  c_pulse_end: cover property ($fell(WAKE_IRQ));
  c_dac_off: cover property ($fell(DAC_POWER_ON));
  c_read_frame: cover property ($fell(MDIO_OE_N));
endmodule : pxc_regs_checker

bind pxc_regs pxc_regs_checker i_chk (.*);

/* File: pxc_mdio_host.sv */
// management host model driving clause-22 frames
`timescale 1ns/1ps
module pxc_mdio_host (
  // clock
  input wire logic clk,
  // management pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  int half = 2;
  logic drv = 1'b1;
  // released line rests at the pull-up level
  assign mdio_in = mdio_oe_n ? drv : mdio_out;
  initial mdc = 1'b0;
  // one frame; clock stands low between frames, half sets host speed
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hffffffff, 2'b01, op, 5'h01, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdc = 1'b0;
      drv = (op == 2'h2 && i < 18) ? 1'b1 : fr[i];
      repeat (half) @(posedge clk);
      #1 rd = {rd[14:0], mdio_in};
      mdc = 1'b1;
      repeat (half) @(posedge clk);
      #1;
    end
    mdc = 1'b0;
    drv = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : xfer
endmodule : pxc_mdio_host

/* File: pxc_regs_tb_top.sv */
// self-checking bench for the extended configuration register block
`timescale 1ns/1ps
`include "pxc_regs_map.svh"
module pxc_regs_tb_top;
  import pxc_pkg::*;
  localparam int P1MS = 50;
  localparam int P10MS = 80;
  // ---------------------------------------------------------
  // design connections
  // ---------------------------------------------------------
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic MDC, MDIO_IN, MDIO_OUT, MDIO_OE_N;
  logic CLK_SEL_STRAP = 1'b1;
  logic RECEIVE_DATA_ONE_STRAP_STRAP = 1'b1;
  logic RX_ERR_EVENT = 1'b0;
  logic TEN_MEG_MODE = 1'b0;
  logic TX_ACTIVE = 1'b0;
  logic ISOLATE = 1'b0;
  logic RX_DV_IN = 1'b0;
  logic CRS_DV_IN = 1'b0;
  logic GENERAL_IRQ = 1'b0;
  logic WAKE_EVENT = 1'b0;
  logic WAKE_IRQ_CLEAR = 1'b0;
  logic LED0_STATUS = 1'b0;
  logic DAC_POWER_ON, REMOTE_LOOPBACK, JUMBO_ENABLE, CRS_DV_PIN;
  logic WAKE_DETECT_ON, TXC_IS_INPUT, RXC_IS_INPUT, RXC_FROM_DAC;
  logic WAKE_IRQ, LED0_PIN;
  logic [47:0] WAKE_STATION_ADDR;
  pxc_mac_mode_type MAC_MODE;
  int fails = 0;
  int compares = 0;
  int cnt;
  logic [15:0] v;
  logic [15:0] adr [3];
  // clock at 40 MHz
  always #12.5 CLK_SYS = ~CLK_SYS;
  pxc_regs #(.PULSE_1MS_CYCLES(P1MS), .PULSE_10MS_CYCLES(P10MS)) i_dut (.*);
  pxc_mdio_host i_host (.clk(CLK_SYS), .mdc(MDC), .mdio_in(MDIO_IN),
    .mdio_out(MDIO_OUT), .mdio_oe_n(MDIO_OE_N));
  // ---------------------------------------------------------
  // expectations and access tasks
  // ---------------------------------------------------------
  function automatic logic dac_exp(logic b, logic t, logic a);
    return !(b && t && !a);
  endfunction : dac_exp
  function automatic int pulse_len(int s);
    case (s)
      0: return 400;
      1: return 4000;
      2: return P1MS;
      default: return P10MS;
    endcase
  endfunction : pulse_len
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : tick
  task automatic mw(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    i_host.xfer(`PXC_OP_WRITE, ra, d, unused);
  endtask : mw
  task automatic mr(input logic [4:0] ra, output logic [15:0] d);
    i_host.xfer(`PXC_OP_READ, ra, 16'h0000, d);
  endtask : mr
  // extended access: index first, then the window
  task automatic ew(input logic [15:0] idx, input logic [15:0] d);
    mw(`PXC_ADDR_INDEX, idx);
    mw(`PXC_ADDR_WINDOW, d);
  endtask : ew
  task automatic er(input logic [15:0] idx, output logic [15:0] d);
    mw(`PXC_ADDR_INDEX, idx);
    mr(`PXC_ADDR_WINDOW, d);
  endtask : er
  task automatic wake_pulse();
    WAKE_EVENT = 1'b1;
    tick(1);
    WAKE_EVENT = 1'b0;
  endtask : wake_pulse
  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // watchdog against a hung handshake
  initial begin
    repeat (99000) @(posedge CLK_SYS);
    fails++;
    end_of_test();
  end
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    cnt = $urandom(32'he365);
    tick(2);
    RST = 1'b0;
    tick(3);
    check(16'(MAC_MODE), 16'h0001);
    check(16'(TXC_IS_INPUT), 16'h0001);
    mr(`PXC_ADDR_INDEX, v);
    check(v, `PXC_RST_ZERO);
    mr(5'h10, v);
    check(v, `PXC_RST_ZERO);
    er(`PXC_EXT_TEN_PWR, v);
    check(v, `PXC_RST_TEN_PWR);
    er(`PXC_EXT_COMBO, v);
    check(v, 16'h0001);
    er(`PXC_EXT_PAD, v);
    check(v, `PXC_RST_PAD);
    er(`PXC_EXT_COMBO2, v);
    check(v, `PXC_RST_COMBO2);
    // station address words through a slow host
    i_host.half = 8;
    for (int i = 0; i < 3; i++) begin
      adr[i] = 16'($urandom);
      ew(`PXC_EXT_ADDR_HIGH + 16'(i), adr[i]);
    end
    i_host.half = 2;
    check(WAKE_STATION_ADDR[47:32], adr[0]);
    check(WAKE_STATION_ADDR[31:16], adr[1]);
    check(WAKE_STATION_ADDR[15:0], adr[2]);
    er(`PXC_EXT_ADDR_MID, v);
    check(v, adr[1]);
    ew(16'h4002, 16'hffff);
    er(16'h4002, v);
    check(v, `PXC_RST_ZERO);
    // error tally: counted burst, clear on read, saturation
    cnt = 1 + $urandom % 20;
    for (int i = 0; i < cnt; i++) begin
      RX_ERR_EVENT = 1'b1;
      tick(1);
      RX_ERR_EVENT = 1'b0;
      tick(1);
    end
    mr(`PXC_ADDR_ERR_TALLY, v);
    check(v, 16'(cnt));
    mw(`PXC_ADDR_ERR_TALLY, 16'h1234);
    mr(`PXC_ADDR_ERR_TALLY, v);
    check(v, `PXC_RST_ZERO);
    RX_ERR_EVENT = 1'b1;
    tick(65540);
    RX_ERR_EVENT = 1'b0;
    mr(`PXC_ADDR_ERR_TALLY, v);
    check(v, `PXC_TALLY_MAX);
    // every interface mode with the control bits flipping
    for (int m = 0; m < 4; m++) begin
      v = (m[0] ? 16'h0834 : 16'h0000) ^ (16'($urandom) & 16'h0010);
      v = v | 16'(m);
      RX_DV_IN = 1'($urandom);
      CRS_DV_IN = ~RX_DV_IN;
      ew(`PXC_EXT_COMBO, v);
      check(16'(REMOTE_LOOPBACK), 16'(v[11]));
      check(16'(JUMBO_ENABLE), 16'(v[5]));
      check(16'(CRS_DV_PIN), 16'(v[4] ? RX_DV_IN : CRS_DV_IN));
      check(16'(WAKE_DETECT_ON), 16'(v[2]));
      check(16'(TXC_IS_INPUT), 16'(v[0]));
      check(16'(MAC_MODE), 16'(m));
    end
    // dac shutoff over all idle conditions
    for (int k = 0; k < 8; k++) begin
      if (k % 4 == 0) ew(`PXC_EXT_TEN_PWR, k[2] ? 16'hce02 : 16'hca02);
      TEN_MEG_MODE = k[0];
      TX_ACTIVE = k[1];
      tick(2);
      check(16'(DAC_POWER_ON), 16'(dac_exp(k[2], k[0], k[1])));
    end
    // clock directions while isolated, jitter clock select
    ew(`PXC_EXT_COMBO, `PXC_RST_COMBO);
    ISOLATE = 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = 16'(k) << 5 | (k[0] ? 16'h4000 : 16'h0000) | 16'h0200;
      ew(`PXC_EXT_COMBO2, v);
      check(16'(TXC_IS_INPUT), 16'(k[1]));
      check(16'(RXC_IS_INPUT), 16'(k[0]));
      check(16'(RXC_FROM_DAC), 16'(k[0]));
    end
    ISOLATE = 1'b0;
    tick(2);
    check(16'(TXC_IS_INPUT), 16'h0000);
    // wake pulse width for every width code
    for (int s = 0; s < 4; s++) begin
      ew(`PXC_EXT_COMBO2, 16'(2 * s + 1) << 7);
      wake_pulse();
      cnt = 0;
      for (int c = 0; c < pulse_len(s) + 20; c++) begin
        tick(1);
        cnt += int'(WAKE_IRQ === 1'b1);
      end
      cnt = cnt - pulse_len(s);
      check(16'(cnt >= -1 && cnt <= 1), 16'h0001);
    end
    // drop the level left by the pulse runs before going to level mode
    WAKE_IRQ_CLEAR = 1'b1;
    tick(1);
    WAKE_IRQ_CLEAR = 1'b0;
    // level mode and interrupt routing onto the led pin
    ew(`PXC_EXT_COMBO2, `PXC_RST_ZERO);
    ew(`PXC_EXT_PAD, 16'h00ef);
    GENERAL_IRQ = 1'b1;
    tick(3);
    check(16'(LED0_PIN), 16'h0000);
    wake_pulse();
    tick(20);
    check(16'(WAKE_IRQ), 16'h0001);
    check(16'(LED0_PIN), 16'h0001);
    ew(`PXC_EXT_PAD, `PXC_RST_PAD);
    GENERAL_IRQ = 1'b0;
    tick(3);
    check(16'(LED0_PIN), 16'h0000);
    WAKE_IRQ_CLEAR = 1'b1;
    tick(3);
    WAKE_IRQ_CLEAR = 1'b0;
    check(16'(WAKE_IRQ), 16'h0000);
    // second reset with the other strap values
    CLK_SEL_STRAP = 1'b0;
    RECEIVE_DATA_ONE_STRAP_STRAP = 1'b0;
    RST = 1'b1;
    tick(2);
    RST = 1'b0;
    tick(3);
    LED0_STATUS = 1'b1;
    tick(2);
    check(16'(TXC_IS_INPUT), 16'h0000);
    check(16'(LED0_PIN), 16'h0001);
    check(WAKE_STATION_ADDR[15:0], `PXC_RST_ZERO);
    er(`PXC_EXT_COMBO, v);
    check(v, `PXC_RST_COMBO);
    end_of_test();
  end
endmodule : pxc_regs_tb_top
